// *** verilog/dmv_unit.sv ***
/*
 * dmv_unit: executes four data-move instructions over four quarter phases.
 * assumes the fetch path presents insn_word with insn_valid during phase 1 of
 * each instruction cycle; data memory answers a read in the same cycle.
 */
// Overview of operation
// - file-to-file move copies source byte to destination, source untouched.
// - move addresses are full 12-bit, no bank selection used.
// - move accepts the accumulator as source or destination.
// - move need not support program counter low or stack-top destinations.
// - move: two cycles, read in phase 2, write in second cycle phase 4.
// - bank literal load puts the literal into bank select in one cycle.
// - upper four bank select bits always read zero after the load.
// - accumulator literal load puts the literal into the accumulator.
// - accumulator store writes accumulator to an 8-bit address in one cycle.
// - access bit 0 picks access bank, 1 uses bank select register.
// - extended set, access 0, address up to 5Fh: indexed literal offset.
// - move encoded as 1100 source word then 1111 destination word.
`timescale 1ns/100ps
module dmv_unit
    import dmv_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [1:0] q_phase, // quarter phase 0..3
    input wire logic insn_valid, // instruction word present
    input wire logic [15:0] insn_word, // instruction word
    input wire logic ext_set_en, // extended instruction set enabled
    input wire logic [11:0] index_base, // indexed offset base pointer
    input wire logic [7:0] mem_rdata, // data memory read data
    output logic mem_rd, // data memory read strobe
    output logic mem_wr, // data memory write strobe
    output logic [11:0] mem_addr, // data memory address
    output logic [7:0] mem_wdata, // data memory write data
    output logic [7:0] acc_out, // working accumulator
    output logic [7:0] bank_sel_out, // bank select register
    output logic move_busy, // move in progress, second word or its write pending
    output logic flags_we // status flag write, always low
);
    import dmv_pkg::*;

    dmv_state_t state_r, state_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic [3:0] bank_r, bank_nxt;
    logic [7:0] latch_r, latch_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [7:0] pend_r, pend_nxt;
    logic [11:0] pend_addr_r, pend_addr_nxt;
    logic store_pend_r, store_pend_nxt;
    logic [1:0] rd_kind_r, rd_kind_nxt;
    logic busy_r, busy_nxt;

    // resolve an 8-bit file address into a 12-bit data address
    function automatic logic [11:0] bank_addr(input logic a, input logic [7:0] f,
                                              input logic [3:0] bank_select_register, input logic ext,
                                              input logic [11:0] base);
        if (a) begin
            bank_addr = {bank_select_register, f};
        end else if (ext && f <= DMV_INDEXED_MAX) begin
            bank_addr = base + {4'h0, f};
        end else if (f < DMV_ACCESS_SPLIT) begin
            bank_addr = {4'h0, f};
        end else begin
            bank_addr = {DMV_ACCESS_HI_BANK, f};
        end
    endfunction

    function automatic logic is_bad_dest(input logic [11:0] a);
        is_bad_dest = (a == DMV_PCL_ADDR) || (a >= DMV_STACK_TOP_LOW_BYTE_ADDR && a <= DMV_STACK_TOP_UPPER_BYTE_ADDR);
    endfunction

    always_comb begin
        state_nxt = state_r;
        acc_nxt = acc_r;
        bank_nxt = bank_r;
        latch_nxt = latch_r;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        pend_nxt = pend_r;
        pend_addr_nxt = pend_addr_r;
        store_pend_nxt = 1'b0;
        rd_kind_nxt = 2'h0;
        // capture the source byte while its read strobe stands this cycle
        if (rd_kind_r == 2'h1) begin
            latch_nxt = mem_rdata;
        end
        case (state_r)
            DMV_IDLE: begin
                if (insn_valid && q_phase == 2'h0) begin
                    if (insn_word[15:12] == DMV_OP_MOVE_SRC) begin
                        state_nxt = DMV_MOVE_WAIT;
                        pend_addr_nxt = insn_word[11:0];
                    end else if (insn_word[15:8] == DMV_OP_BANK_LIT) begin
                        bank_nxt = insn_word[3:0];
                    end else if (insn_word[15:8] == DMV_OP_ACC_LIT) begin
                        acc_nxt = insn_word[7:0];
                    end else if (insn_word[15:9] == DMV_OP_ACC_STORE) begin
                        pend_addr_nxt = bank_addr(insn_word[8], insn_word[7:0], bank_r,
                                                  ext_set_en, index_base);
                        pend_nxt = acc_r;
                        store_pend_nxt = 1'b1;
                    end
                end
            end
            DMV_MOVE_WAIT: begin
                // source read in phase 2 of the first cycle
                if (q_phase == DMV_Q2 && !rd_r) begin
                    // full address, accumulator read from its own copy
                    if (pend_addr_r == DMV_ACC_ADDR) begin
                        latch_nxt = acc_r;
                    end else begin
                        rd_nxt = 1'b1;
                        addr_nxt = pend_addr_r;
                        rd_kind_nxt = 2'h1;
                    end
                end
                if (insn_valid && q_phase == 2'h0 && insn_word[15:12] == DMV_OP_MOVE_DST) begin
                    state_nxt = DMV_MOVE_WRITE;
                    pend_addr_nxt = insn_word[11:0];
                end
            end
            DMV_MOVE_WRITE: begin
                // no dummy read; write in phase 4
                if (q_phase == DMV_Q4) begin
                    state_nxt = DMV_IDLE;
                    if (pend_addr_r == DMV_ACC_ADDR) begin
                        acc_nxt = latch_r;
                    // excluded targets are simply not written
                    end else if (!is_bad_dest(pend_addr_r)) begin
                        wr_nxt = 1'b1;
                        addr_nxt = pend_addr_r;
                        wdata_nxt = latch_r;
                    end
                end
            end
            default: begin
                state_nxt = DMV_IDLE;
            end
        endcase
        // store waits for phase 4 of its own cycle
        if (store_pend_r) begin
            store_pend_nxt = 1'b1;
        end
        if (store_pend_r && q_phase == DMV_Q4) begin
            store_pend_nxt = 1'b0;
            if (pend_addr_r == DMV_ACC_ADDR) begin
                acc_nxt = pend_r;
            end else begin
                wr_nxt = 1'b1;
                addr_nxt = pend_addr_r;
                wdata_nxt = pend_r;
            end
        end
        // busy is registered so the output comes straight from a flop
        busy_nxt = (state_nxt != DMV_IDLE);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= DMV_IDLE;
            acc_r <= DMV_ACC_RST;
            bank_r <= DMV_BANK_RST;
            latch_r <= 8'h00;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 12'h000;
            wdata_r <= 8'h00;
            pend_r <= 8'h00;
            pend_addr_r <= 12'h000;
            store_pend_r <= 1'b0;
            rd_kind_r <= 2'h0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            bank_r <= bank_nxt;
            latch_r <= latch_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            pend_r <= pend_nxt;
            pend_addr_r <= pend_addr_nxt;
            store_pend_r <= store_pend_nxt;
            rd_kind_r <= rd_kind_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign mem_rd = rd_r;
    assign mem_wr = wr_r;
    assign mem_addr = addr_r;
    assign mem_wdata = wdata_r;
    assign acc_out = acc_r;
    // upper nibble is not stored at all
    assign bank_sel_out = {4'h0, bank_r};
    assign move_busy = busy_r;
    // these moves never write status flags
    assign flags_we = 1'b0;

    a_flags_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        !flags_we) else $error("status flags written");
    a_bank_upper_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        bank_sel_out[7:4] == 4'h0) else $error("bank upper nibble set");
    a_bank_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == DMV_IDLE && insn_valid && q_phase == 2'h0
         && insn_word[15:8] == DMV_OP_BANK_LIT) |=> bank_sel_out[3:0] == $past(insn_word[3:0]))
        else $error("bank literal not loaded");
    a_acc_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == DMV_IDLE && insn_valid && q_phase == 2'h0
         && insn_word[15:8] == DMV_OP_ACC_LIT) |=> acc_out == $past(insn_word[7:0]))
        else $error("accumulator literal not loaded");
    a_store_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == DMV_IDLE && insn_valid && q_phase == 2'h0 && insn_word[15:9]
         == DMV_OP_ACC_STORE && insn_word[8]) |-> ##4 (mem_wr && mem_wdata == $past(acc_r, 4)))
        else $error("store did not write accumulator");
    a_store_bank: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == DMV_IDLE && insn_valid && q_phase == 2'h0 && insn_word[15:9]
         == DMV_OP_ACC_STORE && insn_word[8]) |-> ##4 mem_addr[11:8] == $past(bank_r, 4))
        else $error("store bank wrong");
    a_move_read_q2: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_rd |-> state_r == DMV_MOVE_WAIT && $past(q_phase) == DMV_Q2)
        else $error("move read outside phase 2");
    a_move_no_bad: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mem_wr && $past(state_r) == DMV_MOVE_WRITE) |-> !is_bad_dest(mem_addr))
        else $error("move wrote excluded target");
endmodule

// *** verilog/dmv_pkg.sv ***
/*
 * dmv_pkg: constants for the data-move instruction unit.
 * assumes a 16-bit instruction word and a 12-bit data address space.
 */
package dmv_pkg;
    localparam int unsigned DMV_ADDR_W = 12;
    localparam int unsigned DMV_INSN_W = 16;
    localparam logic [3:0] DMV_OP_MOVE_SRC = 4'hc;
    localparam logic [3:0] DMV_OP_MOVE_DST = 4'hf;
    localparam logic [7:0] DMV_OP_BANK_LIT = 8'h01;
    localparam logic [7:0] DMV_OP_ACC_LIT = 8'h0e;
    localparam logic [6:0] DMV_OP_ACC_STORE = 7'h37;
    localparam logic [7:0] DMV_INDEXED_MAX = 8'h5f;
    localparam logic [7:0] DMV_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] DMV_ACCESS_HI_BANK = 4'hf;
    localparam logic [11:0] DMV_ACC_ADDR = 12'hfe8;
    localparam logic [11:0] DMV_PCL_ADDR = 12'hff9;
    localparam logic [11:0] DMV_STACK_TOP_LOW_BYTE_ADDR = 12'hffd;
    localparam logic [11:0] DMV_STACK_TOP_UPPER_BYTE_ADDR = 12'hfff;
    localparam logic [7:0] DMV_ACC_RST = 8'h00;
    localparam logic [3:0] DMV_BANK_RST = 4'h0;
    localparam logic [1:0] DMV_Q2 = 2'h1;
    localparam logic [1:0] DMV_Q4 = 2'h3;
    typedef enum logic [1:0] {
        DMV_IDLE = 2'b00,
        DMV_MOVE_WAIT = 2'b01,
        DMV_MOVE_WRITE = 2'b10
    } dmv_state_t;
endpackage

// *** bench/dmv_mem_model.sv ***
/*
 * dmv_mem_model: behavioural data memory on the far side of the move unit.
 * assumes one clock; a read answers while the read strobe stands.
 */
`timescale 1ns/100ps
module dmv_mem_model (
    input wire logic core_clk, // core clock
    input wire logic mem_rd, // read strobe
    input wire logic mem_wr, // write strobe
    input wire logic [11:0] mem_addr, // byte address, full data space
    input wire logic [7:0] mem_wdata, // write data
    output logic [7:0] mem_rdata // read data
);
    logic [7:0] mem [4096];
    // outside an answer the bus shows inverted data, so it never passes as valid
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
    always @(posedge core_clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule

// *** bench/testbench.sv ***
/*
 * testbench: drives fetch-side words into the move unit and judges memory.
 * assumes the behavioural memory model; the bench runs the quarter phases.
 */
`timescale 1ns/100ps
module testbench;
    import dmv_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] q_phase = 2'h0;
    logic insn_valid = 1'b0;
    logic [15:0] insn_word = 16'h0000;
    logic ext_set_en = 1'b0;
    logic [11:0] index_base = 12'h000;
    logic [7:0] mem_rdata;
    logic mem_rd;
    logic mem_wr;
    logic move_busy;
    logic flags_we;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] acc_out;
    logic [7:0] bank_sel_out;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int rd_cyc = 0;
    int wr_cyc = 0;
    int rd_cnt = 0;

    always #25 core_clk = ~core_clk;

    dmv_unit u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .q_phase(q_phase),
        .insn_valid(insn_valid), .insn_word(insn_word), .ext_set_en(ext_set_en),
        .index_base(index_base), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .acc_out(acc_out), .bank_sel_out(bank_sel_out), .move_busy(move_busy),
        .flags_we(flags_we));
    dmv_mem_model u_mem (.core_clk(core_clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        q_phase <= sys_rst ? 2'h0 : q_phase + 2'h1;
        if (mem_rd === 1'b1) begin
            rd_cyc <= cyc;
            rd_cnt <= rd_cnt + 1;
        end
        if (mem_wr === 1'b1) begin
            wr_cyc <= cyc;
        end
        if (!sys_rst) chk("flags_we", 16'(flags_we), 16'h0000);
        if (cyc == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // a word is offered only where the next edge is a phase-1 take
    task automatic issue(input logic [15:0] w);
        do @(posedge core_clk); while (q_phase !== 2'h3);
        insn_valid <= 1'b1;
        insn_word <= w;
        @(posedge core_clk);
        insn_valid <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic store(input logic a, input logic [7:0] f, input logic [11:0] where);
        u_mem.mem[where] = 8'h00;
        issue({DMV_OP_ACC_STORE, a, f});
        idle(6);
        chk("store target", 16'(u_mem.mem[where]), 16'h003c);
    endtask

    task automatic move(input logic [11:0] src, input logic [11:0] dst);
        issue({DMV_OP_MOVE_SRC, src});
        @(negedge core_clk);
        chk("move busy", 16'(move_busy), 16'h0001);
        issue({DMV_OP_MOVE_DST, dst});
        idle(6);
        chk("move done", 16'(move_busy), 16'h0000);
    endtask

    task automatic t_literals;
        issue({DMV_OP_ACC_LIT, 8'h3c});
        issue({DMV_OP_BANK_LIT, 8'hf5});
        idle(2);
        chk("accumulator", 16'(acc_out), 16'h003c);
        chk("bank select", 16'(bank_sel_out), 16'h0005);
    endtask

    task automatic t_stores;
        store(1'b1, 8'h20, 12'h520);
        store(1'b0, 8'h70, 12'hf70);
        store(1'b0, 8'h10, 12'h010);
        ext_set_en <= 1'b1;
        index_base <= 12'h200;
        store(1'b0, 8'h5f, 12'h25f);
        store(1'b0, 8'h60, 12'hf60);
        store(1'b1, 8'h10, 12'h510);
        ext_set_en <= 1'b0;
    endtask

    task automatic t_move;
        int rc;
        u_mem.mem[12'h123] = 8'h77;
        u_mem.mem[12'habc] = 8'h11;
        rc = rd_cnt;
        move(12'h123, 12'habc);
        chk("move dest", 16'(u_mem.mem[12'habc]), 16'h0077);
        chk("move src", 16'(u_mem.mem[12'h123]), 16'h0077);
        chk("move reads", 16'(rd_cnt - rc), 16'h0001);
        chk("read to write", 16'(wr_cyc - rd_cyc), 16'h0006);
    endtask

    task automatic t_move_acc;
        u_mem.mem[DMV_ACC_ADDR] = 8'hee;
        u_mem.mem[12'h345] = 8'h00;
        move(DMV_ACC_ADDR, 12'h345);
        chk("acc as source", 16'(u_mem.mem[12'h345]), 16'h003c);
        u_mem.mem[12'h456] = 8'h99;
        move(12'h456, DMV_ACC_ADDR);
        chk("acc as dest", 16'(acc_out), 16'h0099);
        u_mem.mem[DMV_PCL_ADDR] = 8'h44;
        move(12'h123, DMV_PCL_ADDR);
        chk("pc low kept", 16'(u_mem.mem[DMV_PCL_ADDR]), 16'h0044);
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_literals();
        t_stores();
        t_move();
        t_move_acc();
        tally_and_finish();
    end
endmodule
